// file: core/modem_param_status_bank.sv
// Purpose: Host-visible bank of modem parameters and V.34 status words
// Assumes: Estimates and negotiation results come from the modem core as inputs
// Notes: Read data stand in the cycle after the read strobe only
//
// Function
// - Longest ring period resets to A0, matching a 15 Hz ring.
// - Shortest ring period resets to 23, matching a 68 Hz ring.
// - Ring pulses count only when their period, in 2400 Hz ticks, lies between the limits.
// - A shortest-period value of zero makes the call alert follow the bell sense input.
// - Jitter estimates are given only in V.34 mode and only when the core has locked.
// - Jitter frequency word N gives N times the symbol rate over 2^16 Hz.
// - Jitter amplitude word magnitude over 90 gives degrees.
// - Transmit trellis mapping is a two-bit read-only field valid after carrier detect.
// - Bit 0 of the CRC select register picks CRC-32 at zero, CRC-16 at one, default one.
// - Read-only bits flag warping for transmit and receive.
// - Read-only bits flag transmit and receive precoding after carrier detect.
// - Bit 15 of each shaping word flags transmit and receive shaping.
// - The symbol rate code is shown once the aux receive state reaches 4X.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module modem_param_status_bank (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Ring path
  input wire logic bell_sense_input_i,
  output logic call_alert_bit_o,
  // Modem core status
  input wire logic line_signal_detect_i,
  input wire logic [7:0] aux_rx_state_i,
  input wire logic v34_mode_i,
  input wire logic jitter_lock_i,
  input wire logic [15:0] jitter_freq_i,
  input wire logic [15:0] jitter_ampl_i,
  input wire logic [1:0] trellis_tx_i,
  input wire logic warping_tx_i,
  input wire logic warping_rx_i,
  input wire logic precoding_tx_i,
  input wire logic precoding_rx_i,
  input wire logic shaping_tx_i,
  input wire logic shaping_rx_i,
  input wire logic [2:0] symbol_rate_i,
  // Control outputs
  output logic crc16_sel_o
);

  localparam int TICK_W = 15;

  logic [7:0] ring_min_reg;
  logic [7:0] ring_max_reg;
  logic crc_sel_reg;
  logic [15:0] jfreq_reg;
  logic [15:0] jampl_reg;
  logic [1:0] trellis_reg;
  logic warp_tx_reg;
  logic warp_rx_reg;
  logic prec_tx_reg;
  logic prec_rx_reg;
  logic shape_tx_reg;
  logic shape_rx_reg;
  logic [2:0] rate_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [7:0] period_reg;
  logic bell_d_reg;
  logic alert_reg;
  logic tick;
  logic rise;
  logic period_ok;
  logic [15:0] rdata_next;

  // Host-writable parameters; status locations ignore writes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ring_max_reg <= modem_param_pkg::RING_MAX_RESET;
      ring_min_reg <= modem_param_pkg::RING_MIN_RESET;
      crc_sel_reg <= modem_param_pkg::CRC_SEL_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == modem_param_pkg::OFF_RING_MAX) begin
        ring_max_reg <= reg_wdata_i[7:0];
      end else if (reg_addr_i == modem_param_pkg::OFF_RING_MIN) begin
        ring_min_reg <= reg_wdata_i[7:0];
      end else if (reg_addr_i == modem_param_pkg::OFF_CRC_TYPE) begin
        crc_sel_reg <= reg_wdata_i[modem_param_pkg::CRC_SEL_BIT];
      end
    end
  end

  // Jitter estimates held at zero outside V.34; in V.34 latched on lock, else held
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !v34_mode_i) begin
      jfreq_reg <= 16'h0000;
      jampl_reg <= 16'h0000;
    end else if (jitter_lock_i) begin
      jfreq_reg <= jitter_freq_i;
      jampl_reg <= jitter_ampl_i;
    end
  end

  // Negotiation results captured while carrier detect holds
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      trellis_reg <= 2'h0;
      warp_tx_reg <= 1'b0;
      warp_rx_reg <= 1'b0;
      prec_tx_reg <= 1'b0;
      prec_rx_reg <= 1'b0;
      shape_tx_reg <= 1'b0;
      shape_rx_reg <= 1'b0;
    end else if (line_signal_detect_i) begin
      trellis_reg <= trellis_tx_i;
      warp_tx_reg <= warping_tx_i;
      warp_rx_reg <= warping_rx_i;
      prec_tx_reg <= precoding_tx_i;
      prec_rx_reg <= precoding_rx_i;
      shape_tx_reg <= shaping_tx_i;
      shape_rx_reg <= shaping_rx_i;
    end
  end

  // Symbol rate code, held from the point the aux state reaches 4X
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rate_reg <= 3'h0;
    end else if (aux_rx_state_i[7:4] == modem_param_pkg::AUX_RATE_VALID) begin
      rate_reg <= symbol_rate_i;
    end
  end

  // 2400 Hz tick so periods compare directly with 2400/F limits
  assign tick = (tick_cnt_reg == TICK_W'(modem_param_pkg::RING_TICK_CYCLES - 1));

  always_ff @(posedge core_clk_i) begin
    if (srst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
    end
  end

  // Period counter saturates, so very slow rings stay out of range
  assign rise = bell_sense_input_i && !bell_d_reg;
  assign period_ok = (period_reg >= ring_min_reg) && (period_reg <= ring_max_reg);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bell_d_reg <= 1'b0;
      period_reg <= 8'h00;
    end else begin
      bell_d_reg <= bell_sense_input_i;
      if (rise) begin
        period_reg <= 8'h00;
      end else if (tick && period_reg != 8'hFF) begin
        period_reg <= period_reg + 8'h01;
      end
    end
  end

  // Alert follows the input in bypass, else tracks qualified pulses
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      alert_reg <= 1'b0;
    end else if (ring_min_reg == modem_param_pkg::RING_BYPASS) begin
      alert_reg <= bell_sense_input_i;
    end else if (rise) begin
      alert_reg <= period_ok;
    end else if (tick && period_reg == ring_max_reg) begin
      alert_reg <= 1'b0; // Ring stopped: no edge within longest period
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (reg_addr_i == modem_param_pkg::OFF_RING_MAX) begin
      rdata_next = {8'h00, ring_max_reg};
    end else if (reg_addr_i == modem_param_pkg::OFF_RING_MIN) begin
      rdata_next = {8'h00, ring_min_reg};
    end else if (reg_addr_i == modem_param_pkg::OFF_CRC_TYPE) begin
      rdata_next[modem_param_pkg::CRC_SEL_BIT] = crc_sel_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_JITTER_FREQ) begin
      rdata_next = jfreq_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_JITTER_AMPL) begin
      rdata_next = jampl_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_TRELLIS_TX) begin
      rdata_next[modem_param_pkg::TRELLIS_LSB +: 2] = trellis_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_WARPING_TX) begin
      rdata_next[modem_param_pkg::WARPING_BIT] = warp_tx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_WARPING_RX) begin
      rdata_next[modem_param_pkg::WARPING_BIT] = warp_rx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_PRECODING_TX) begin
      rdata_next[modem_param_pkg::PRECODING_TX_BIT] = prec_tx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_PRECODING_RX) begin
      rdata_next[modem_param_pkg::PRECODING_RX_BIT] = prec_rx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_SHAPING_TX) begin
      rdata_next[modem_param_pkg::SHAPING_BIT] = shape_tx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_SHAPING_RX) begin
      rdata_next[modem_param_pkg::SHAPING_BIT] = shape_rx_reg;
    end else if (reg_addr_i == modem_param_pkg::OFF_SYMBOL_RATE) begin
      rdata_next = {13'h0000, rate_reg};
    end
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !reg_rd_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // Registered outputs
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      call_alert_bit_o <= 1'b0;
      crc16_sel_o <= modem_param_pkg::CRC_SEL_RESET;
    end else begin
      call_alert_bit_o <= alert_reg;
      crc16_sel_o <= crc_sel_reg;
    end
  end

endmodule

// file: core/modem_param_pkg.sv
// Purpose: Shared constants for the modem parameter and status bank
// Assumes: Register offsets are word indexes on the plain register port
// Notes: Timing is expressed in cycles of the 50 MHz core clock
package modem_param_pkg;
  // Register offsets
  localparam logic [11:0] OFF_PRECODING_RX = 12'h052;
  localparam logic [11:0] OFF_CRC_TYPE = 12'h0B3;
  localparam logic [11:0] OFF_RING_MIN = 12'h21E;
  localparam logic [11:0] OFF_RING_MAX = 12'h21F;
  localparam logic [11:0] OFF_SYMBOL_RATE = 12'h2E3;
  localparam logic [11:0] OFF_PRECODING_TX = 12'h2FD;
  localparam logic [11:0] OFF_TRELLIS_TX = 12'h375;
  localparam logic [11:0] OFF_JITTER_FREQ = 12'h80D;
  localparam logic [11:0] OFF_JITTER_AMPL = 12'h80E;
  localparam logic [11:0] OFF_SHAPING_RX = 12'h9F8;
  localparam logic [11:0] OFF_SHAPING_TX = 12'hA49;
  localparam logic [11:0] OFF_WARPING_RX = 12'hC00;
  localparam logic [11:0] OFF_WARPING_TX = 12'hC08;
  // Field positions
  localparam int CRC_SEL_BIT = 0;
  localparam int PRECODING_RX_BIT = 2;
  localparam int PRECODING_TX_BIT = 3;
  localparam int TRELLIS_LSB = 3;
  localparam int SHAPING_BIT = 15;
  localparam int WARPING_BIT = 10;
  // Reset values
  localparam logic [7:0] RING_MAX_RESET = 8'hA0;
  localparam logic [7:0] RING_MIN_RESET = 8'h23;
  localparam logic [7:0] RING_BYPASS = 8'h00;
  localparam logic CRC_SEL_RESET = 1'b1;
  // Aux receive state high nibble marking symbol rate valid
  localparam logic [3:0] AUX_RATE_VALID = 4'h4;
  // Ring period tick: 1/2400 s in ns, then cycles at 20 ns
  localparam int RING_TICK_NS = 416667;
  localparam int CLK_PERIOD_NS = 20;
  localparam int RING_TICK_CYCLES = RING_TICK_NS / CLK_PERIOD_NS;
endpackage

// file: tb/modem_param_status_bank_assertions.sv
// Purpose: Port-level assertions for the modem parameter and status bank
// Assumes: One clock domain, synchronous active-high reset
// Notes: Status checks need the core inputs held across the read
`timescale 1ns/100ps
module modem_param_status_bank_assertions (
  // Clock, reset and register port
  input wire logic core_clk_i, srst_i, reg_wr_i, reg_rd_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  // Ring path, control and status
  input wire logic bell_sense_input_i, call_alert_bit_o, crc16_sel_o,
  input wire logic line_signal_detect_i, v34_mode_i, warping_tx_i,
  input wire logic [7:0] aux_rx_state_i,
  input wire logic [1:0] trellis_tx_i,
  input wire logic [2:0] symbol_rate_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Bypass is not visible at the ports, so shadow it from bus writes
  logic byp_reg;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) byp_reg <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 12'h21E) byp_reg <= reg_wdata_i[7:0] == 8'h00;
  end
  property p_max_rst;
    $past(srst_i, 2) && reg_rd_i && reg_addr_i == 12'h21F |=> reg_rdata_o == 16'h00A0;
  endproperty
  a_max_rst: assert property (p_max_rst) else $error("ring max period reset value wrong");
  property p_bypass;
    byp_reg && $past(byp_reg, 3) |-> call_alert_bit_o == $past(bell_sense_input_i, 2);
  endproperty
  a_bypass: assert property (p_bypass) else $error("alert does not follow bell input");
  property p_crc_wr;
    reg_wr_i && reg_addr_i == 12'h0B3 |=> ##1 crc16_sel_o == $past(reg_wdata_i[0], 2);
  endproperty
  a_crc_wr: assert property (p_crc_wr) else $error("check type select not taken");
  property p_crc_rst;
    $past(srst_i) |-> crc16_sel_o;
  endproperty
  a_crc_rst: assert property (p_crc_rst) else $error("check type not 16-bit after reset");
  property p_trellis;
    line_signal_detect_i && $past(line_signal_detect_i) && $stable(trellis_tx_i) && reg_rd_i
      && reg_addr_i == 12'h375 |=> reg_rdata_o == {11'h000, $past(trellis_tx_i), 3'h0};
  endproperty
  a_trellis: assert property (p_trellis) else $error("trellis field wrong");
  property p_warp;
    line_signal_detect_i && $past(line_signal_detect_i) && $stable(warping_tx_i) && reg_rd_i
      && reg_addr_i == 12'hC08 |=> reg_rdata_o == {5'h00, $past(warping_tx_i), 10'h000};
  endproperty
  a_warp: assert property (p_warp) else $error("warping flag wrong");
  property p_rate;
    aux_rx_state_i[7:4] == 4'h4 && $past(aux_rx_state_i[7:4]) == 4'h4 && $stable(symbol_rate_i)
      && reg_rd_i && reg_addr_i == 12'h2E3 |=> reg_rdata_o == {13'h0000, $past(symbol_rate_i)};
  endproperty
  a_rate: assert property (p_rate) else $error("symbol rate code wrong");
  property p_nov34;
    !v34_mode_i && !$past(v34_mode_i) && reg_rd_i && reg_addr_i == 12'h80E |=> reg_rdata_o == 16'h0000;
  endproperty
  a_nov34: assert property (p_nov34) else $error("jitter estimate shown outside V.34");
endmodule
bind modem_param_status_bank modem_param_status_bank_assertions modem_param_status_bank_assertions_inst (
  .core_clk_i, .srst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .bell_sense_input_i, .call_alert_bit_o, .crc16_sel_o, .line_signal_detect_i, .v34_mode_i,
  .warping_tx_i, .aux_rx_state_i, .trellis_tx_i, .symbol_rate_i);

// file: tb/host_model.sv
// Purpose: Host processor model mastering the plain register port
// Assumes: The slave never stalls; read data stand one cycle after the strobe
// Notes: Strobes drop one edge later, so calls always leave a gap
`timescale 1ns/100ps
module host_model (
  // Clock
  input wire logic core_clk_i,
  // Register port
  output logic [11:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i
);
  // Idle bus at time zero
  initial begin
    reg_addr_o = 12'h000;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One-cycle write; check type choice rides in bit 0
  task automatic write(input logic [11:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
  endtask
  // Status is read only after its validity condition, never written
  task automatic read(input logic [11:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

// file: tb/modem_param_status_bank_tb_top.sv
// Purpose: Self-checking bench for the modem parameter and status bank
// Assumes: Host model owns the register port
// Notes: Ring period qualification is too slow at the real tick rate
`timescale 1ns/100ps
module modem_param_status_bank_tb_top;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reg_wr_i, reg_rd_i, call_alert_bit_o, crc16_sel_o, jitter_lock_i = 1'b1;
  logic bell_sense_input_i = 1'b0, line_signal_detect_i = 1'b1, v34_mode_i = 1'b1;
  logic [11:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, jitter_freq_i, jitter_ampl_i, st = 16'h0000;
  logic [7:0] aux_rx_state_i = 8'h40;
  logic [1:0] trellis_tx_i;
  logic [2:0] symbol_rate_i;
  logic warping_tx_i, warping_rx_i, precoding_tx_i, precoding_rx_i, shaping_tx_i, shaping_rx_i;
  int num_errors = 0, checked = 0, cycles = 0;
  typedef struct packed {logic [11:0] a; logic [15:0] s; logic [15:0] e;} row_t;
  row_t rows [17] = '{'{12'h375, 16'h0001, 16'h0008}, '{12'h375, 16'h0003, 16'h0018},
    '{12'hC08, 16'h0004, 16'h0400}, '{12'hC00, 16'h0008, 16'h0400},
    '{12'hC08, 16'h0008, 16'h0000}, '{12'h2FD, 16'h0010, 16'h0008},
    '{12'h052, 16'h0020, 16'h0004}, '{12'hA49, 16'h0040, 16'h8000},
    '{12'h9F8, 16'h0080, 16'h8000}, '{12'h2E3, 16'h0000, 16'h0000},
    '{12'h2E3, 16'h0200, 16'h0002}, '{12'h2E3, 16'h0300, 16'h0003},
    '{12'h2E3, 16'h0400, 16'h0004}, '{12'h2E3, 16'h0500, 16'h0005},
    '{12'h001, 16'h0000, 16'h0000}, '{12'h80E, 16'hF321, 16'hF321},
    '{12'h80D, 16'h05CB, 16'h05CB}};
  // One word feeds the negotiation, symbol rate and jitter inputs
  assign {symbol_rate_i, shaping_rx_i, shaping_tx_i, precoding_rx_i, precoding_tx_i,
    warping_rx_i, warping_tx_i, trellis_tx_i} = st[10:0];
  assign jitter_freq_i = st;
  assign jitter_ampl_i = st;
  always #10 core_clk_i = ~core_clk_i;
  modem_param_status_bank modem_param_status_bank_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .bell_sense_input_i(bell_sense_input_i),
    .call_alert_bit_o(call_alert_bit_o), .line_signal_detect_i(line_signal_detect_i),
    .aux_rx_state_i(aux_rx_state_i), .v34_mode_i(v34_mode_i), .jitter_lock_i(jitter_lock_i),
    .jitter_freq_i(jitter_freq_i), .jitter_ampl_i(jitter_ampl_i), .trellis_tx_i(trellis_tx_i),
    .warping_tx_i(warping_tx_i), .warping_rx_i(warping_rx_i), .precoding_tx_i(precoding_tx_i),
    .precoding_rx_i(precoding_rx_i), .shaping_tx_i(shaping_tx_i), .shaping_rx_i(shaping_rx_i),
    .symbol_rate_i(symbol_rate_i), .crc16_sel_o(crc16_sel_o));
  host_model host_model_inst (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_model_inst.read(a, d);
    chk(d, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, well above the roughly 180 cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(12'h21F, 16'h00A0);
    rd(12'h21E, 16'h0023);
    chk({15'h0000, crc16_sel_o}, 16'h0001);
    chk({15'h0000, call_alert_bit_o}, 16'h0000);
    foreach (rows[i]) begin
      st <= rows[i].s;
      repeat (3) @(posedge core_clk_i);
      rd(rows[i].a, rows[i].e);
    end
    // Validity conditions drop: captured words must hold
    line_signal_detect_i <= 1'b0;
    aux_rx_state_i <= 8'h30;
    jitter_lock_i <= 1'b0;
    @(posedge core_clk_i);
    st <= 16'h0000;
    repeat (3) @(posedge core_clk_i);
    rd(12'h2E3, 16'h0005);
    rd(12'h375, 16'h0018);
    rd(12'h80D, 16'h05CB);
    v34_mode_i <= 1'b0;
    rd(12'h80E, 16'h0000);
    // Check type select both ways, then a limit written back
    host_model_inst.write(12'h0B3, 16'h0000);
    repeat (2) @(posedge core_clk_i);
    chk({15'h0000, crc16_sel_o}, 16'h0000);
    rd(12'h0B3, 16'h0000);
    host_model_inst.write(12'h0B3, 16'h0001);
    repeat (2) @(posedge core_clk_i);
    chk({15'h0000, crc16_sel_o}, 16'h0001);
    host_model_inst.write(12'h21F, 16'h0055);
    rd(12'h21F, 16'h0055);
    // Zero shortest period: alert tracks the bell input
    host_model_inst.write(12'h21E, 16'h0000);
    bell_sense_input_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk({15'h0000, call_alert_bit_o}, 16'h0001);
    bell_sense_input_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk({15'h0000, call_alert_bit_o}, 16'h0000);
    // Mid-run reset must return the limits and the check type to their reset values
    host_model_inst.write(12'h0B3, 16'h0000);
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(12'h21F, 16'h00A0);
    rd(12'h21E, 16'h0023);
    chk({15'h0000, crc16_sel_o}, 16'h0001);
    wrap_up();
  end
endmodule
